// ### src/hrx_regs.svh
// register map, field positions, codes and counts of the hdlc receive port
`ifndef HRX_REGS_SVH
`define HRX_REGS_SVH
`define HRX_A_CTRL    8'hB0
`define HRX_A_LIVE    8'hB4
`define HRX_A_LATCH   8'hB6
`define HRX_A_IE      8'hB8
`define HRX_A_DATA    8'hBC
`define HRX_CTRL_RST  16'h0800
`define HRX_CTRL_MASK 16'h1F0F
`define HRX_EV_MASK   16'h009D
`define HRX_F_THR     12:8
`define HRX_B_FLUSH   0
`define HRX_B_CHKDIS  1
`define HRX_B_INV     2
`define HRX_B_SWAP    3
`define HRX_L_AVAIL   0
`define HRX_L_EMPTY   1
`define HRX_L_FULL    2
`define HRX_E_PSTART  3
`define HRX_E_PEND    4
`define HRX_E_OVF     7
`define HRX_PS_MID    3'h0
`define HRX_PS_START  3'h1
`define HRX_PS_GOOD   3'h4
`define HRX_PS_FCSERR 3'h5
`define HRX_PS_BADLEN 3'h6
`define HRX_PS_ABORT  3'h7
`define HRX_DEPTH     9'h100
`define HRX_WAKE_CYC  4'h8
`define HRX_ONES_STF  3'h5
`define HRX_ONES_FLG  3'h6
`define HRX_ONES_MAX  3'h7
`define HRX_PC_EMIT   4'hE
`define HRX_PC_FLAG   4'h7
`define HRX_CRC_INIT  16'hFFFF
`define HRX_CRC_GOOD  16'hF0B8
`define HRX_CRC_POLY  16'h8408
`endif

// ### src/hrx_pkg.sv
// types shared by the hdlc receive port
package hrx_pkg;
  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } hrx_bus_s;
  typedef struct packed {
    logic [2:0] status;
    logic [7:0] data;
  } hrx_entry_s;
  typedef enum logic [3:0] {
    ST_OFF   = 4'h1,
    ST_WAKE  = 4'h2,
    ST_HUNT  = 4'h4,
    ST_FRAME = 4'h8
  } hrx_state_e;
endpackage

// ### src/hrx_port.sv
// hdlc receive packet processor with 256-byte fifo and register set
// Behaviour
// - threshold counts eight-byte groups
// - swap bit puts first bit in msb
// - invert bit inverts incoming data
// - check-disable bit skips fcs check
// - flush bit empties, halts, powers down
// - after flush, wake then hunt flag
// - live full flag at 256 bytes
// - live empty flag when nothing stored
// - live avail flag at or above threshold
// - overflow sets latched overflow bit
// - packet end write sets latched bit
// - packet start write sets latched bit
// - full and avail latch on rise
// - enabled latched events gated by port enable
// - upper data byte read advances fifo
// - status shown belongs to same byte
// - three-bit status code per byte
// - valid bit low when fifo empty
`include "hrx_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module hrx_port (
  // clock and reset
  input  wire logic             clock_i,
  input  wire logic             rst_n_i,
  // register port
  input  wire hrx_pkg::hrx_bus_s bus_i,
  output logic [15:0]           rd_data_o,
  // serial overhead bits
  input  wire logic             rx_bit_i,
  input  wire logic             rx_bit_en_i,
  // interrupt and power
  input  wire logic             port_global_irq_en_i,
  output logic                  irq_o,
  output logic                  ram_pwr_down_o
);
  import hrx_pkg::*;

  function automatic logic [7:0] hrx_rev8(input logic [7:0] b);
    logic [7:0] r;
    r = '0;
    for (int i = 0; i < 8; i++) begin
      r[i] = b[7-i];
    end
    return r;
  endfunction

  function automatic logic [15:0] hrx_crc8(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ b[i]) ? ((r >> 1) ^ `HRX_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  logic [15:0] ctrl_q;
  logic [15:0] ie_q;
  logic [15:0] latch_q;
  logic [15:0] rd_data_q;
  hrx_entry_s  mem [0:255];
  logic [7:0]  wptr_q;
  logic [7:0]  rptr_q;
  logic [8:0]  cnt_q;
  hrx_state_e  st_q;
  logic [2:0]  ones_q;
  logic [14:0] sr_q;
  logic [3:0]  pc_q;
  logic [7:0]  held_q;
  logic        held_v_q;
  logic        first_q;
  logic [15:0] crc_q;
  logic [3:0]  wake_q;
  logic        full_prev_q;
  logic        avail_prev_q;

  logic        flush;
  logic        bit_in;
  logic        bit_act;
  logic        flag_ev;
  logic        abort_ev;
  logic        data_bit;
  logic        emit;
  logic        pop;
  logic        fifo_full;
  logic        fifo_empty;
  logic        avail;
  logic [8:0]  thr;
  logic        wr_en;
  logic        accept;
  hrx_entry_s  wr_entry;
  logic [15:0] ev_set;
  logic [14:0] sr_ins;

  assign flush      = ctrl_q[`HRX_B_FLUSH];
  assign bit_in     = rx_bit_i ^ ctrl_q[`HRX_B_INV];
  // the receiver only leaves its state on the edge after flush rises, so gate bits here too
  assign bit_act    = rx_bit_en_i && !flush && (st_q == ST_HUNT || st_q == ST_FRAME);
  assign flag_ev    = bit_act && !bit_in && ones_q == `HRX_ONES_FLG;
  assign abort_ev   = bit_act && bit_in && ones_q >= `HRX_ONES_FLG;
  assign data_bit   = bit_act && st_q == ST_FRAME && !flag_ev && !abort_ev
                      && !(!bit_in && ones_q == `HRX_ONES_STF);
  // a byte leaves the pending window only once 7 bits follow it, since
  // those 7 bits may still be the start of a closing flag
  assign emit       = data_bit && pc_q == `HRX_PC_EMIT;
  assign pop        = bus_i.rd && bus_i.addr == `HRX_A_DATA && !fifo_empty;
  assign fifo_full  = cnt_q == `HRX_DEPTH;
  assign fifo_empty = cnt_q == 9'h000;
  assign thr        = {1'b0, ctrl_q[`HRX_F_THR], 3'h0};
  assign avail      = !flush && cnt_q >= thr;
  assign accept     = wr_en && (!fifo_full || pop);
  assign ram_pwr_down_o = flush;
  assign rd_data_o  = rd_data_q;
  assign irq_o      = port_global_irq_en_i && |(latch_q & ie_q);

  always_comb begin
    sr_ins = sr_q;
    sr_ins[pc_q] = bit_in;
  end

  // closing byte is held back so its status can say how the frame ended
  always_comb begin
    wr_en = 1'b0;
    wr_entry.data = held_q;
    wr_entry.status = first_q ? `HRX_PS_START : `HRX_PS_MID;
    if (held_v_q && st_q == ST_FRAME) begin
      if (emit) begin
        wr_en = 1'b1;
      end else if (flag_ev) begin
        wr_en = 1'b1;
        if (pc_q != `HRX_PC_FLAG) begin
          wr_entry.status = `HRX_PS_BADLEN;
        end else if (ctrl_q[`HRX_B_CHKDIS] || crc_q == `HRX_CRC_GOOD) begin
          wr_entry.status = `HRX_PS_GOOD;
        end else begin
          wr_entry.status = `HRX_PS_FCSERR;
        end
      end else if (abort_ev) begin
        wr_en = 1'b1;
        wr_entry.status = `HRX_PS_ABORT;
      end
    end
  end

  always_comb begin
    ev_set = '0;
    ev_set[`HRX_E_OVF]    = wr_en && !accept;
    ev_set[`HRX_E_PEND]   = accept && wr_entry.status[2];
    ev_set[`HRX_E_PSTART] = accept && wr_entry.status == `HRX_PS_START;
    ev_set[`HRX_L_FULL]   = fifo_full && !full_prev_q;
    ev_set[`HRX_L_AVAIL]  = avail && !avail_prev_q;
  end

  // receive state
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q   <= ST_HUNT;
      wake_q <= 4'h0;
    end else if (flush) begin
      st_q   <= ST_OFF;
      wake_q <= 4'h0;
    end else begin
      unique case (st_q)
        ST_OFF: begin
          st_q <= ST_WAKE;
        end
        ST_WAKE: begin
          wake_q <= wake_q + 4'h1;
          if (wake_q == `HRX_WAKE_CYC - 4'h1) begin
            st_q <= ST_HUNT;
          end
        end
        ST_HUNT: begin
          if (flag_ev) begin
            st_q <= ST_FRAME;
          end
        end
        ST_FRAME: begin
          if (abort_ev) begin
            st_q <= ST_HUNT;
          end
        end
      endcase
    end
  end

  // flag, stuffing and byte assembly
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ones_q   <= 3'h0;
      sr_q     <= '0;
      pc_q     <= 4'h0;
      held_q   <= 8'h00;
      held_v_q <= 1'b0;
      first_q  <= 1'b1;
      crc_q    <= `HRX_CRC_INIT;
    end else if (flush) begin
      ones_q   <= 3'h0;
      pc_q     <= 4'h0;
      held_v_q <= 1'b0;
    end else begin
      if (bit_act) begin
        ones_q <= !bit_in ? 3'h0 : (ones_q == `HRX_ONES_MAX) ? ones_q : ones_q + 3'h1;
      end
      if (flag_ev || abort_ev) begin
        pc_q     <= 4'h0;
        held_v_q <= 1'b0;
        first_q  <= 1'b1;
        crc_q    <= `HRX_CRC_INIT;
      end else if (emit) begin
        sr_q     <= {8'h00, sr_ins[14:8]};
        pc_q     <= `HRX_PC_FLAG;
        held_q   <= ctrl_q[`HRX_B_SWAP] ? hrx_rev8(sr_ins[7:0]) : sr_ins[7:0];
        held_v_q <= 1'b1;
        crc_q    <= hrx_crc8(crc_q, sr_ins[7:0]);
        if (wr_en) begin
          first_q <= 1'b0;
        end
      end else if (data_bit) begin
        sr_q <= sr_ins;
        pc_q <= pc_q + 4'h1;
      end
    end
  end

  // fifo storage; contents are undefined after a flush, only pointers and count reset
  always_ff @(posedge clock_i) begin
    if (accept && !flush) begin
      mem[wptr_q] <= wr_entry;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wptr_q <= 8'h00;
      rptr_q <= 8'h00;
      cnt_q  <= 9'h000;
    end else if (flush) begin
      wptr_q <= 8'h00;
      rptr_q <= 8'h00;
      cnt_q  <= 9'h000;
    end else begin
      if (accept) begin
        wptr_q <= wptr_q + 8'h01;
      end
      if (pop) begin
        rptr_q <= rptr_q + 8'h01;
      end
      cnt_q <= cnt_q + {8'h00, accept} - {8'h00, pop};
    end
  end

  // software registers
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_q <= `HRX_CTRL_RST;
      ie_q   <= 16'h0000;
    end else if (bus_i.wr) begin
      if (bus_i.addr == `HRX_A_CTRL) begin
        ctrl_q <= bus_i.wdata & `HRX_CTRL_MASK;
      end
      if (bus_i.addr == `HRX_A_IE) begin
        ie_q <= bus_i.wdata & `HRX_EV_MASK;
      end
    end
  end

  // set wins over a clear arriving in the same cycle
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      latch_q      <= 16'h0000;
      full_prev_q  <= 1'b0;
      avail_prev_q <= 1'b0;
    end else begin
      full_prev_q  <= fifo_full;
      avail_prev_q <= avail;
      if (bus_i.wr && bus_i.addr == `HRX_A_LATCH) begin
        latch_q <= ((latch_q & ~bus_i.wdata) | ev_set) & `HRX_EV_MASK;
      end else begin
        latch_q <= (latch_q | ev_set) & `HRX_EV_MASK;
      end
    end
  end

  // read data lives one cycle after the strobe
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_data_q <= 16'h0000;
    end else begin
      rd_data_q <= 16'h0000;
      if (bus_i.rd) begin
        unique case (bus_i.addr)
          `HRX_A_CTRL:  rd_data_q <= ctrl_q;
          `HRX_A_LIVE:  rd_data_q <= {13'h0000, fifo_full, fifo_empty, avail};
          `HRX_A_LATCH: rd_data_q <= latch_q;
          `HRX_A_IE:    rd_data_q <= ie_q;
          `HRX_A_DATA: begin
            if (!fifo_empty) begin
              // status and valid describe the same byte that this read pops
              rd_data_q <= {mem[rptr_q].data, 4'h0, mem[rptr_q].status, 1'b1};
            end
          end
          default:      rd_data_q <= 16'h0000;
        endcase
      end
    end
  end

  sequence s_wake;
    !wr_en [*8];
  endsequence
  sequence s_live_rd;
    bus_i.rd && bus_i.addr == `HRX_A_LIVE;
  endsequence

  property p_thr;
    @(posedge clock_i) disable iff (!rst_n_i)
    s_live_rd |=> rd_data_o[`HRX_L_AVAIL] == ($past(cnt_q) >= {1'b0, $past(ctrl_q[`HRX_F_THR]), 3'h0} && !$past(flush));
  endproperty
  a_thr: assert property (p_thr) else $error("avail flag wrong");
  property p_swap;
    @(posedge clock_i) disable iff (!rst_n_i)
    emit |=> held_q == ($past(ctrl_q[`HRX_B_SWAP]) ? hrx_rev8($past(sr_ins[7:0])) : $past(sr_ins[7:0]));
  endproperty
  a_swap: assert property (p_swap) else $error("bit order wrong");
  property p_inv;
    @(posedge clock_i) disable iff (!rst_n_i)
    bit_act && ctrl_q[`HRX_B_INV] && rx_bit_i |=> ones_q == 3'h0;
  endproperty
  a_inv: assert property (p_inv) else $error("inversion missing");
  property p_nochk;
    @(posedge clock_i) disable iff (!rst_n_i)
    wr_en && flag_ev && ctrl_q[`HRX_B_CHKDIS] && pc_q == `HRX_PC_FLAG |-> wr_entry.status == `HRX_PS_GOOD;
  endproperty
  a_nochk: assert property (p_nochk) else $error("fcs not skipped");
  property p_flush;
    @(posedge clock_i) disable iff (!rst_n_i)
    flush |=> cnt_q == 9'h000 && st_q == ST_OFF;
  endproperty
  a_flush: assert property (p_flush) else $error("flush not honoured");
  property p_flush_idle;
    @(posedge clock_i) disable iff (!rst_n_i)
    flush |-> !avail && !accept && ram_pwr_down_o;
  endproperty
  a_flush_idle: assert property (p_flush_idle) else $error("data taken during flush");
  property p_wake;
    @(posedge clock_i) disable iff (!rst_n_i)
    $fell(flush) |-> s_wake;
  endproperty
  a_wake: assert property (p_wake) else $error("data taken during wake");
  property p_fe;
    @(posedge clock_i) disable iff (!rst_n_i)
    s_live_rd |=> rd_data_o[`HRX_L_FULL:`HRX_L_EMPTY] == {$past(cnt_q) == `HRX_DEPTH, $past(cnt_q) == 9'h000};
  endproperty
  a_fe: assert property (p_fe) else $error("full or empty flag wrong");
  property p_ovf;
    @(posedge clock_i) disable iff (!rst_n_i)
    wr_en && fifo_full && !pop |=> latch_q[`HRX_E_OVF] && cnt_q == `HRX_DEPTH;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow not latched");
  property p_rise;
    @(posedge clock_i) disable iff (!rst_n_i)
    $rose(fifo_full) |=> latch_q[`HRX_L_FULL];
  endproperty
  a_rise: assert property (p_rise) else $error("full rise not latched");
  property p_pop;
    @(posedge clock_i) disable iff (!rst_n_i || flush)
    bus_i.rd && bus_i.addr == `HRX_A_DATA |=> rptr_q == $past(rptr_q) + {7'h00, !$past(fifo_empty)};
  endproperty
  a_pop: assert property (p_pop) else $error("fifo advance wrong");
  property p_empty_rd;
    @(posedge clock_i) disable iff (!rst_n_i)
    bus_i.rd && bus_i.addr == `HRX_A_DATA && fifo_empty |=> rd_data_o == 16'h0000;
  endproperty
  a_empty_rd: assert property (p_empty_rd) else $error("valid set on empty");
  property p_hold;
    @(posedge clock_i) disable iff (!rst_n_i)
    latch_q[`HRX_E_PEND] && !(bus_i.wr && bus_i.addr == `HRX_A_LATCH) |=> latch_q[`HRX_E_PEND];
  endproperty
  a_hold: assert property (p_hold) else $error("latched bit lost");
endmodule
`default_nettype wire

// ### dv/hrx_bit_src.sv
// serial bit source standing in for the overhead extraction path
`timescale 1ns/1ps
`default_nettype none
module hrx_bit_src (
  // clock
  input  wire logic clock_i,
  // serial bits toward the port
  output logic      bit_o,
  output logic      bit_en_o
);
  int   ones;
  logic inv;
  initial begin
    bit_o = 1'b0;
    bit_en_o = 1'b0;
    inv = 1'b0;
    ones = 0;
  end
  // between bits the line shows the inverse, so a stale level never passes
  task automatic put(input logic b, input int gap);
    @(posedge clock_i);
    bit_o <= b ^ inv;
    bit_en_o <= 1'b1;
    if (gap > 0) begin
      @(posedge clock_i);
      bit_en_o <= 1'b0;
      bit_o <= ~(b ^ inv);
      repeat (gap - 1) @(posedge clock_i);
    end
  endtask
  task automatic dbit(input logic b, input int gap);
    put(b, gap);
    ones = b ? ones + 1 : 0;
    if (ones == 5) begin
      put(1'b0, gap);
      ones = 0;
    end
  endtask
  task automatic flag(input int gap);
    for (int i = 0; i < 8; i++) put(i != 0 && i != 7, gap);
    ones = 0;
  endtask
  // kind 0 closes with a flag, 1 aborts with seven ones, 2 adds three stray bits
  task automatic send(input logic [7:0] q[$], input int kind, input int gap);
    flag(gap);
    foreach (q[k]) for (int i = 0; i < 8; i++) dbit(q[k][i], gap);
    if (kind == 1) for (int i = 0; i < 7; i++) put(1'b1, gap);
    if (kind == 2) for (int i = 0; i < 3; i++) dbit(1'b0, gap);
    flag(gap);
    @(posedge clock_i);
    bit_en_o <= 1'b0;
    bit_o <= ~bit_o;
  endtask
endmodule
`default_nettype wire

// ### dv/testbench.sv
// self-checking bench of the hdlc receive port
`timescale 1ns/1ps
`default_nettype none
`include "hrx_regs.svh"
module testbench;
  import hrx_pkg::*;
  logic        clock_i = 1'b0;
  logic        rst_n_i = 1'b0;
  hrx_bus_s    bus_i = '0;
  logic        port_global_irq_en_i = 1'b0;
  logic [15:0] rd_data_o;
  logic        rx_bit_i;
  logic        rx_bit_en_i;
  logic        irq_o;
  logic        ram_pwr_down_o;
  int          fails = 0;
  int          tests_run = 0;
  int          seed = 81799;
  logic [15:0] v;
  logic [15:0] r;
  logic [7:0]  q[$];
  logic [15:0] exp_q[$];
  always #20 clock_i = ~clock_i;
  hrx_port dut (
    .clock_i              (clock_i),
    .rst_n_i              (rst_n_i),
    .bus_i                (bus_i),
    .rd_data_o            (rd_data_o),
    .rx_bit_i             (rx_bit_i),
    .rx_bit_en_i          (rx_bit_en_i),
    .port_global_irq_en_i (port_global_irq_en_i),
    .irq_o                (irq_o),
    .ram_pwr_down_o       (ram_pwr_down_o)
  );
  hrx_bit_src src (
    .clock_i  (clock_i),
    .bit_o    (rx_bit_i),
    .bit_en_o (rx_bit_en_i)
  );
  task automatic tally_and_finish;
    if (fails == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    tests_run++;
    if (seen !== want) begin
      fails++;
      $display("unexpected at %0t: seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock_i);
    bus_i <= '{a, d, 1'b1, 1'b0};
    @(posedge clock_i);
    bus_i <= '0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clock_i);
    bus_i <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge clock_i);
    bus_i <= '0;
    #1 v = rd_data_o;
  endtask
  function automatic logic [15:0] ent(input logic [7:0] b, input logic [2:0] s, input logic sw);
    logic [7:0] o;
    for (int i = 0; i < 8; i++) o[i] = sw ? b[7 - i] : b[i];
    return {o, 4'h0, s, 1'b1};
  endfunction
  function automatic logic [15:0] fcs(input logic [7:0] d[$]);
    logic [15:0] c;
    c = `HRX_CRC_INIT;
    foreach (d[k]) for (int i = 0; i < 8; i++)
      c = (c >> 1) ^ ((c[0] ^ d[k][i]) ? `HRX_CRC_POLY : 16'h0000);
    return ~c;
  endfunction
  // one frame: expected entries queued, latched events checked and cleared
  task automatic frame(input int n, input int kind, input logic [15:0] cfg,
                       input logic bad, input logic dr, input logic [15:0] xl);
    logic [15:0] c;
    logic [2:0]  es;
    int          m;
    q.delete();
    for (int k = 0; k < n; k++) q.push_back(8'($random(seed)));
    if (kind == 0 && !cfg[`HRX_B_CHKDIS]) begin
      c = fcs(q) ^ {15'h0000, bad};
      q.push_back(c[7:0]);
      q.push_back(c[15:8]);
    end
    es = kind == 1 ? `HRX_PS_ABORT : kind == 2 ? `HRX_PS_BADLEN :
         bad ? `HRX_PS_FCSERR : `HRX_PS_GOOD;
    // an abort loses the last byte, still inside the flag window; the one before ends it
    m = q.size() - (kind == 1 ? 1 : 0);
    for (int k = 0; k < m; k++) exp_q.push_back(ent(q[k], k == m - 1 ? es :
      k == 0 ? `HRX_PS_START : `HRX_PS_MID, cfg[`HRX_B_SWAP]));
    wr(`HRX_A_CTRL, cfg);
    src.inv = cfg[`HRX_B_INV];
    src.send(q, kind, $unsigned($random(seed)) % 3);
    repeat (4) @(posedge clock_i);
    c = xl | 16'h0010 | (m > 1 ? 16'h0008 : 16'h0000) |
        (exp_q.size() >= 8 * cfg[12:8] ? 16'h0001 : 16'h0000);
    rd(`HRX_A_LATCH);
    check(v, c);
    wr(`HRX_A_LATCH, c);
    rd(`HRX_A_LATCH);
    check(v, 16'h0000);
    if (dr) begin
      rd(`HRX_A_LIVE);
      check(v, 16'h0000);
      while (exp_q.size() > 0) begin
        rd(`HRX_A_DATA);
        check(v, exp_q.pop_front());
      end
      rd(`HRX_A_DATA);
      check(v, 16'h0000);
      rd(`HRX_A_LIVE);
      check(v, 16'h0002);
    end
  endtask
  initial begin
    repeat (20) @(posedge clock_i);
    rst_n_i <= 1'b1;
    rd(`HRX_A_CTRL);
    check(v, `HRX_CTRL_RST);
    rd(`HRX_A_LIVE);
    check(v, 16'h0002);
    rd(`HRX_A_LATCH);
    check(v, 16'h0000);
    rd(8'hB2);
    check(v, 16'h0000);
    rd(`HRX_A_DATA);
    check(v, 16'h0000);
    r = 16'($random(seed));
    wr(`HRX_A_IE, r);
    rd(`HRX_A_IE);
    check(v, r & `HRX_EV_MASK);
    wr(`HRX_A_CTRL, r & 16'hFFFE);
    rd(`HRX_A_CTRL);
    check(v, r & 16'hFFFE & `HRX_CTRL_MASK);
    wr(`HRX_A_LIVE, 16'hFFFF);
    wr(`HRX_A_LATCH, 16'hFFFF);
    rd(`HRX_A_LIVE);
    check(v, 16'h0002 | {15'h0000, r[12:8] == 5'h00});
    // every mix of swap, invert and check-disable; a single-byte frame among them
    for (int c = 0; c < 8; c++)
      frame(c == 3 ? 1 : 2 + $unsigned($random(seed)) % 5, 0, 16'h0800 | 16'(c << 1), 0, 1, 0);
    frame(4, 0, 16'h0800, 1, 1, 0);
    frame(3, 1, 16'h0808, 0, 1, 0);
    frame(3, 2, 16'h0802, 0, 1, 0);
    frame(8, 0, 16'h0102, 0, 0, 0);
    rd(`HRX_A_LIVE);
    check(v, 16'h0001);
    rd(`HRX_A_DATA);
    check(v, exp_q.pop_front());
    rd(`HRX_A_LIVE);
    check(v, 16'h0000);
    frame(249, 0, 16'h0102, 0, 0, 16'h0004);
    rd(`HRX_A_LIVE);
    check(v, 16'h0005);
    q = '{8'hA5};
    src.send(q, 0, 1);
    repeat (4) @(posedge clock_i);
    rd(`HRX_A_LATCH);
    check(v & 16'h0080, 16'h0080);
    wr(`HRX_A_IE, 16'h0080);
    #1 check({15'h0000, irq_o}, 16'h0000);
    @(posedge clock_i);
    port_global_irq_en_i <= 1'b1;
    @(posedge clock_i);
    #1 check({15'h0000, irq_o}, 16'h0001);
    wr(`HRX_A_IE, 16'h0004);
    #1 check({15'h0000, irq_o}, 16'h0000);
    wr(`HRX_A_IE, 16'h0080);
    wr(`HRX_A_LATCH, `HRX_EV_MASK);
    #1 check({15'h0000, irq_o}, 16'h0000);
    rd(`HRX_A_DATA);
    check(v, exp_q.pop_front());
    rd(`HRX_A_LIVE);
    check(v, 16'h0001);
    // flush while data is stored and bits keep arriving
    wr(`HRX_A_CTRL, 16'h0103);
    #1 check({15'h0000, ram_pwr_down_o}, 16'h0001);
    rd(`HRX_A_LIVE);
    check(v, 16'h0002);
    q = '{8'h3C, 8'h5A};
    src.send(q, 0, 0);
    rd(`HRX_A_DATA);
    check(v, 16'h0000);
    wr(`HRX_A_CTRL, 16'h0102);
    #1 check({15'h0000, ram_pwr_down_o}, 16'h0000);
    rd(`HRX_A_LATCH);
    check(v, 16'h0000);
    exp_q.delete();
    repeat (12) @(posedge clock_i);
    frame(2, 0, 16'h0102, 0, 1, 0);
    tally_and_finish();
  end
  // the run needs well under half of this span
  initial begin
    repeat (60000) @(posedge clock_i);
    fails++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
